// ===== testbench/dcl_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host processor model: drives the write port and the update and control reset pins
module dcl_host_model (
    input wire logic clk_in,
    output logic wr_strobe_out,
    output logic wr_enable_n_out,
    output logic [dcl_pkg::ADDR_W-1:0] wr_addr_out,
    output logic [dcl_pkg::BYTE_W-1:0] wr_data_out,
    output logic update_n_out,
    output logic ctl_reset_out
);
    import dcl_pkg::*;

    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        wr_strobe_out = 1'b0;
        wr_enable_n_out = 1'b1;
        wr_addr_out = 4'hF;
        wr_data_out = 8'hA5;
        update_n_out = 1'b1;
        ctl_reset_out = 1'b0;
    end

    // One byte per edge at most, well under the host write ceiling at this clock
    // Released lines show the inverse so a stale byte never looks valid
    task automatic write_byte(input logic [ADDR_W-1:0] addr, input logic [BYTE_W-1:0] data,
                              input logic hold);
        wr_strobe_out = 1'b1;
        wr_enable_n_out = 1'b0;
        wr_addr_out = addr;
        wr_data_out = data;
        @(negedge clk_in);
        if (!hold) begin
            wr_strobe_out = 1'b0;
            wr_enable_n_out = 1'b1;
            wr_addr_out = ~addr;
            wr_data_out = ~data;
        end
    endtask

    // Writes may follow from the very next edge
    task automatic ctl_pulse();
        ctl_reset_out = 1'b1;
        @(negedge clk_in);
        ctl_reset_out = 1'b0;
    endtask

    // Transfer strobe, one edge low
    task automatic update();
        update_n_out = 1'b0;
        @(negedge clk_in);
        update_n_out = 1'b1;
    endtask
endmodule

`default_nettype wire

// ===== testbench/dds_control_latency_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dds_control_latency_tb;
    import dcl_pkg::*;

    logic clk_in;
    logic rst_in;
    logic wr_strobe;
    logic wr_enable_n;
    logic [ADDR_W-1:0] wr_addr;
    logic [BYTE_W-1:0] wr_data;
    logic update_n;
    logic ctl_reset;
    logic [PH_SEL_W-1:0] phase_select;
    logic offset_freq_enable;
    logic [SAMP_W-1:0] sample;
    logic sample_valid;
    logic sample_ready;
    logic [SAMP_W-1:0] s [0:23];
    logic [PH_SEL_W-1:0] p_old;
    logic [PH_SEL_W-1:0] p_new;
    logic [SAMP_W-1:0] last;
    logic [SAMP_W-1:0] held_val;
    logic have;
    logic held;
    int failures;
    int checked;
    integer seed;

    dcl_host_model host (
        .clk_in(clk_in),
        .wr_strobe_out(wr_strobe),
        .wr_enable_n_out(wr_enable_n),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data),
        .update_n_out(update_n),
        .ctl_reset_out(ctl_reset)
    );

    dcl_core DUT (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_strobe_in(wr_strobe),
        .wr_enable_n_in(wr_enable_n),
        .wr_addr_in(wr_addr),
        .wr_data_in(wr_data),
        .update_n_in(update_n),
        .phase_select_in(phase_select),
        .offset_freq_enable_in(offset_freq_enable),
        .ctl_reset_in(ctl_reset),
        .sample_out(sample),
        .sample_valid_out(sample_valid),
        .sample_ready_in(sample_ready)
    );

    // 100 ns sample clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic complete_run();
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [SAMP_W-1:0] exp,
                         input logic [SAMP_W-1:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [SAMP_W-1:0] phase_word(input logic [PH_SEL_W-1:0] p);
        return SAMP_W'(p) << PH_QUARTER_SHIFT;
    endfunction

    // Per-sample step seen in the top 16 accumulator bits
    function automatic logic [SAMP_W-1:0] step_of(input logic [SAMP_W-1:0] cf,
                                                  input logic [SAMP_W-1:0] of, input logic en);
        return cf + (en ? of : 16'h0000);
    endfunction

    function automatic logic [SAMP_W-1:0] delta(input int k);
        return s[k] - s[k-1];
    endfunction

    // s[k] is the output seen after the k-th edge from the event's edge
    task automatic capture();
        for (int k = 0; k < 24; k++) begin
            @(negedge clk_in);
            s[k] = sample;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        checked = 0;
        seed = 32'h88897F02;
        rst_in = 1'b1;
        phase_select = 2'h0;
        offset_freq_enable = 1'b0;
        sample_ready = 1'b1;
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 20 && sample_valid !== 1'b1; i++) begin
            @(negedge clk_in);
        end
        check("valid after reset", 16'h0001, {15'h0, sample_valid});
        if (sample_valid !== 1'b1) begin
            complete_run();
        end
        check("reset sample", phase_word(2'h0), sample);
        // Every phase code, then random ones, at zero frequency
        for (int i = 0; i < 8; i++) begin
            p_old = phase_select;
            p_new = (i < 4) ? PH_SEL_W'(i + 1) : PH_SEL_W'($random(seed));
            phase_select = p_new;
            capture();
            check("phase before", phase_word(p_old), s[LAT_PHASE - 1]);
            check("phase after", phase_word(p_new), s[LAT_PHASE]);
            check("phase offset", phase_word(p_new), s[LAT_PHASE + 1]);
        end
        // Shadow bytes and junk on unmapped places must not move the output
        host.write_byte(4'h4, 8'h01, 1'b1);
        host.write_byte(4'h5, 8'h02, 1'b1);
        for (int i = 0; i < 4; i++) begin
            host.write_byte(4'(i < 2 ? 6 + i : 12 + i), 8'($random(seed)), i < 3);
        end
        capture();
        check("no transfer", 16'h0000, delta(5));
        fork
            host.update();
            capture();
        join
        check("late old", 16'h0000, delta(LAT_UPD_AFTER - 1));
        check("late new", step_of(16'h0201, 16'h0, 1'b0), delta(LAT_UPD_AFTER));
        // Transfer first, write one edge later: the write still lands
        fork
            begin
                host.update();
                host.write_byte(4'h4, 8'h05, 1'b0);
            end
            capture();
        join
        check("early old", step_of(16'h0201, 16'h0, 1'b0), delta(LAT_UPD_BEFORE - 1));
        check("early new", step_of(16'h0205, 16'h0, 1'b0), delta(LAT_UPD_BEFORE));
        host.write_byte(4'hC, 8'h10, 1'b0);
        host.update();
        capture();
        offset_freq_enable = 1'b1;
        capture();
        check("offset old", step_of(16'h0205, 16'h10, 1'b0), delta(LAT_OFS - 1));
        check("offset new", step_of(16'h0205, 16'h10, 1'b1), delta(LAT_OFS));
        // Control reset with a write on its own edge (dropped) and one after (kept)
        phase_select = 2'h1;
        capture();
        fork
            begin
                fork
                    host.ctl_pulse();
                    host.write_byte(4'h5, 8'h01, 1'b1);
                join
                host.write_byte(4'h4, 8'h03, 1'b0);
            end
            capture();
        join
        check("reset running", 16'h0215, delta(LAT_RESET - 1));
        check("reset value", phase_word(2'h1), s[LAT_RESET]);
        check("reset hold", phase_word(2'h1), s[LAT_RESET + 1]);
        fork
            host.update();
            capture();
        join
        check("write after reset", 16'h0003, delta(LAT_UPD_AFTER));
        // Random receiver stalls: held words stay put, none goes missing
        have = 1'b0;
        held = 1'b0;
        for (int i = 0; i < 60; i++) begin
            sample_ready = 1'($random(seed));
            if (held) begin
                check("held word", held_val, sample);
            end
            if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
                if (have) begin
                    check("stream step", last + 16'h0003, sample);
                end
                last = sample;
                have = 1'b1;
            end
            held = sample_valid === 1'b1 && sample_ready === 1'b0;
            held_val = sample;
            @(negedge clk_in);
        end
        complete_run();
    end
endmodule

`default_nettype wire

// ===== verilog/dcl_buf.sv
`timescale 1ns/100ps
`default_nettype none

module dcl_buf (
    input wire logic clk_in,
    input wire logic rst_in,
    dcl_stream_if.snk in_st,
    output logic [dcl_pkg::SAMP_W-1:0] data_out,
    output logic valid_out,
    input wire logic ready_in
);
    import dcl_pkg::*;

    logic [SAMP_W-1:0] mem_reg [BUF_DEPTH];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    // Ready looks only at the count, so a stalled receiver stops the generator
    assign in_st.ready = (count_reg != BUF_FULL);
    assign valid_out = (count_reg != 2'h0);
    assign push = in_st.valid && in_st.ready;
    assign pop = valid_out && ready_in;
    assign data_out = mem_reg[rd_ptr_reg];

    // Storage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_reg[0] <= SAMP_RESET;
            mem_reg[1] <= SAMP_RESET;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_st.data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    hold_stall_a: assert property (@(posedge clk_in) disable iff (rst_in)
        valid_out && !ready_in |=> valid_out && $stable(data_out))
        else $error("buffer output changed while stalled");
    full_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
        count_reg == BUF_FULL && !pop |=> count_reg == BUF_FULL && !in_st.ready)
        else $error("full buffer accepted a word");

endmodule

`default_nettype wire

// ===== verilog/dcl_core.sv
`timescale 1ns/100ps
`default_nettype none

module dcl_core (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_strobe_in,
    input wire logic wr_enable_n_in,
    input wire logic [dcl_pkg::ADDR_W-1:0] wr_addr_in,
    input wire logic [dcl_pkg::BYTE_W-1:0] wr_data_in,
    input wire logic update_n_in,
    input wire logic [dcl_pkg::PH_SEL_W-1:0] phase_select_in,
    input wire logic offset_freq_enable_in,
    input wire logic ctl_reset_in,
    output logic [dcl_pkg::SAMP_W-1:0] sample_out,
    output logic sample_valid_out,
    input wire logic sample_ready_in
);
    import dcl_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [BYTE_W-1:0] shadow_reg [SHADOW_BYTES];
    logic [BYTE_W-1:0] active_reg [SHADOW_BYTES];
    logic [SHADOW_BYTES-1:0] byte_sel;
    logic [ACC_W-1:0] cf_word;
    logic [ACC_W-1:0] of_word;
    logic dirty_reg;
    logic dirty_next;
    logic [TAP_UPD_LATE:0] late_reg;
    logic [TAP_UPD_EARLY:0] early_reg;
    logic [TAP_PHASE:0][PH_SEL_W-1:0] ph_reg;
    logic [TAP_OFS:0] ofs_reg;
    logic [TAP_RESET:0] rs_reg;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic [ACC_W-1:0] freq;
    logic [SAMP_W-1:0] sample_reg;
    logic [SAMP_W-1:0] sample_next;
    logic [SAMP_W-1:0] ph_offset;
    logic sample_valid_reg;
    logic wr_take;
    logic upd_take;
    logic upd_late;
    logic upd_early;
    logic xfer;
    logic rs_hit;
    logic advance;
    logic [3:0] warm_reg;

    dcl_stream_if st ();

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    // Pins other than rst_in are only looked at through clocked logic below, never as
    // asynchronous controls
    assign wr_take = wr_strobe_in && !wr_enable_n_in && !ctl_reset_in; // R06
    assign upd_take = !update_n_in && !ctl_reset_in;
    // An update with new bytes pending takes the long path
    assign upd_late = upd_take && dirty_reg; // R01
    // An update with nothing pending arms a copy of later writes
    assign upd_early = upd_take && !dirty_reg; // R02
    assign xfer = late_reg[TAP_UPD_LATE] || early_reg[TAP_UPD_EARLY];
    assign rs_hit = rs_reg[TAP_RESET];
    assign advance = st.ready;

    // Dirty flag: a write in the same cycle as an update wins
    assign dirty_next = wr_take ? 1'b1 : (upd_take ? 1'b0 : dirty_reg);

    // ------------------------------------------------------------
    // Shadow bytes and word assembly
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SHADOW_BYTES; gi++) begin : g_byte
            localparam logic [ADDR_W-1:0] BYTE_ADDR = (gi < WORD_BYTES) ?
                ADDR_CF_BASE + ADDR_W'(gi) : ADDR_OF_BASE + ADDR_W'(gi - WORD_BYTES);
            assign byte_sel[gi] = wr_take && (wr_addr_in == BYTE_ADDR);

            // Writes only touch the shadow copy
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    shadow_reg[gi] <= BYTE_RESET;
                end else if (ctl_reset_in) begin
                    shadow_reg[gi] <= BYTE_RESET; // R06
                end else if (byte_sel[gi]) begin
                    shadow_reg[gi] <= wr_data_in; // R09
                end
            end

            if (gi < WORD_BYTES) begin : g_cf
                assign cf_word[gi*BYTE_W +: BYTE_W] = active_reg[gi];
            end else begin : g_of
                assign of_word[(gi-WORD_BYTES)*BYTE_W +: BYTE_W] = active_reg[gi];
            end
        end
    endgenerate

    // Shadow to active in one edge, so a 48-bit word never tears
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            active_reg <= '{default: BYTE_RESET};
        end else if (rs_hit) begin
            active_reg <= '{default: BYTE_RESET}; // R05
        end else if (xfer) begin
            active_reg <= shadow_reg; // R09
        end
    end

    // Pending-write flag
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dirty_reg <= 1'b0;
        end else if (ctl_reset_in) begin
            dirty_reg <= 1'b0;
        end else begin
            dirty_reg <= dirty_next;
        end
    end

    // ------------------------------------------------------------
    // Latency delay lines
    // ------------------------------------------------------------
    // Each pin is registered on the edge, then walks a fixed line so the
    // effect lands at the output exactly on its documented cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            late_reg <= '0;
            early_reg <= '0;
        end else if (ctl_reset_in) begin
            late_reg <= '0;
            early_reg <= '0;
        end else begin
            late_reg <= {late_reg[TAP_UPD_LATE-1:0], upd_late}; // R01 R08
            early_reg <= {early_reg[TAP_UPD_EARLY-1:0], upd_early}; // R02 R08
        end
    end

    // Phase, offset enable and reset lines ignore the control reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ph_reg <= '0;
            ofs_reg <= '0;
            rs_reg <= '0;
        end else begin
            ph_reg <= {ph_reg[TAP_PHASE-1:0], phase_select_in}; // R03 R08
            ofs_reg <= {ofs_reg[TAP_OFS-1:0], offset_freq_enable_in}; // R04 R08
            rs_reg <= {rs_reg[TAP_RESET-1:0], ctl_reset_in}; // R05 R08
        end
    end

    // ------------------------------------------------------------
    // Oscillator
    // ------------------------------------------------------------
    // Sum wraps modulo 2^48; offset term zeroed by the delayed enable
    assign freq = cf_word + (ofs_reg[TAP_OFS] ? of_word : ACC_RESET); // R04
    assign acc_next = acc_reg + freq;
    // Quarter-turn steps on the top of the phase word
    assign ph_offset = SAMP_W'({ph_reg[TAP_PHASE], {PH_QUARTER_SHIFT{1'b0}}}); // R10
    assign sample_next = acc_reg[ACC_W-1 -: SAMP_W] + ph_offset; // R03

    // Accumulator stalls with the buffer so no phase step is lost
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_reg <= ACC_RESET;
        end else if (rs_hit) begin
            acc_reg <= ACC_RESET; // R05
        end else if (advance) begin
            acc_reg <= acc_next;
        end
    end

    // Sample stage feeding the buffer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_reg <= SAMP_RESET;
            sample_valid_reg <= 1'b0;
        end else if (advance) begin
            sample_reg <= sample_next;
            sample_valid_reg <= 1'b1;
        end
    end

    assign st.data = sample_reg;
    assign st.valid = sample_valid_reg;

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    // Latencies hold while the receiver keeps ready high; a stall only
    // delays samples, it never drops them
    dcl_buf u_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_st(st.snk),
        .data_out(sample_out),
        .valid_out(sample_valid_out),
        .ready_in(sample_ready_in)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // History counter so delayed comparisons start on known values
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            warm_reg <= 4'h0;
        end else if (warm_reg != 4'hF) begin
            warm_reg <= warm_reg + 4'h1;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // A control reset right after the update would outrun the reset line window
    late_xfer_a: assert property ( // R01
        disable iff (rst_in || ctl_reset_in)
        upd_late |-> ##(TAP_UPD_LATE + 1) (late_reg[TAP_UPD_LATE] || rs_reg != '0))
        else $error("late update not at its transfer slot");
    // Back-to-back updates are legal, so only the early line itself is followed
    early_xfer_a: assert property ( // R02
        upd_early |=> early_reg[0] ##(TAP_UPD_EARLY) (xfer || rs_reg != '0))
        else $error("early update not at its transfer slot");
    phase_delay_a: assert property ( // R03
        warm_reg == 4'hF |-> ph_reg[TAP_PHASE] == $past(phase_select_in, 11))
        else $error("phase select delay wrong");
    offset_delay_a: assert property ( // R04
        warm_reg == 4'hF |-> ofs_reg[TAP_OFS] == $past(offset_freq_enable_in, 12))
        else $error("offset enable delay wrong");
    reset_out_a: assert property ( // R05
        ctl_reset_in |-> ##10 (acc_reg == ACC_RESET && cf_word == ACC_RESET))
        else $error("reset values not reached in time");
    write_open_a: assert property ( // R06
        ctl_reset_in ##1 !ctl_reset_in |-> shadow_reg[0] == BYTE_RESET && !dirty_reg)
        else $error("shadow not cleared by reset");
    shadow_hold_a: assert property ( // R09
        !xfer && !rs_hit |=> $stable(cf_word) && $stable(of_word))
        else $error("active word changed without transfer");
    dirty_clear_a: assert property ( // R09
        upd_take && !wr_take |=> !dirty_reg)
        else $error("update left dirty flag set");

endmodule

`default_nettype wire

// ===== verilog/dcl_pkg.sv
// What this block does
// R01: Update after writes reaches output in 14 cycles
// R02: Update before writes reaches output in 11 cycles
// R03: Phase select reaches output in 12 cycles
// R04: Offset enable reaches output in 14 cycles
// R05: Reset values reach output in 11 cycles
// R06: Writes accepted from one cycle after reset
// R07: Host writes no faster than 50 MSPS
// R08: Control pins captured on the clock edge
// R09: Writes fill shadow; update copies all together
// R10: Phase select adds 0/90/180/270 degrees
`default_nettype none

package dcl_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ACC_W = 48;
    localparam int SAMP_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 4;
    localparam int WORD_BYTES = 6;
    localparam int SHADOW_BYTES = 12;
    localparam int PH_SEL_W = 2;

    // ------------------------------------------------------------
    // Write port map: center word bytes, then offset word bytes
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CF_BASE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OF_BASE = 4'h8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [ACC_W-1:0] ACC_RESET = 48'h0;
    localparam logic [SAMP_W-1:0] SAMP_RESET = 16'h0;

    // Quarter turn of the 16-bit phase word
    localparam int PH_QUARTER_SHIFT = 14;

    // ------------------------------------------------------------
    // Latencies in sample clock cycles
    // ------------------------------------------------------------
    localparam int LAT_UPD_AFTER = 14;
    localparam int LAT_UPD_BEFORE = 11;
    localparam int LAT_PHASE = 12;
    localparam int LAT_OFS = 14;
    localparam int LAT_RESET = 11;
    localparam int LAT_WRITE = 1;
    // Registers between a control change and the output port
    localparam int OUT_PIPE = 3;
    localparam int TAP_UPD_LATE = LAT_UPD_AFTER - OUT_PIPE - 1;
    localparam int TAP_UPD_EARLY = LAT_UPD_BEFORE - OUT_PIPE - 1;
    localparam int TAP_PHASE = LAT_PHASE - (OUT_PIPE - 1);
    localparam int TAP_OFS = LAT_OFS - OUT_PIPE;
    localparam int TAP_RESET = LAT_RESET - OUT_PIPE;

    // ------------------------------------------------------------
    // Host write rate limit
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int WR_RATE_SPS = 50000000;
    localparam int WR_MIN_RAW = (CLK_HZ + WR_RATE_SPS - 1) / WR_RATE_SPS;
    localparam int WR_MIN_CYCLES = (WR_MIN_RAW < 1) ? 1 : WR_MIN_RAW;

    // Two-entry output buffer
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;

endpackage

`default_nettype wire

// ===== verilog/dcl_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

// Sample stream between the generator and its output buffer
interface dcl_stream_if;
    logic [15:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire
